// >>> hw/cpp_pkg.sv
// Package holding widths, reset values and carrier types of the compare PWM period logic
package cpp_pkg;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned CNT_W = 16; // Timer, period and duty width
  localparam int unsigned PRE_W = 8; // Prescale ratio width
  localparam logic [15:0] CNT_RST = 16'h0000; // Timer count after reset
  localparam logic [15:0] DUTY_ZERO = 16'h0000; // Duty value that holds the pin low
  localparam logic [15:0] DUTY_RST = 16'h0000; // Active duty after reset
  localparam logic [7:0] PRE_RST = 8'h00; // Prescale counter after reset
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3; // Four oscillator periods per instruction cycle

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam real OSC_PERIOD_NS = 4.0; // Oscillator period, equal to the block clock
  localparam real CLK_PERIOD_NS = 4.0; // Block clock period at 250 MHz
  localparam int unsigned OSC_CYCLES = (int'(OSC_PERIOD_NS / CLK_PERIOD_NS) < 1) ? 1
                                       : int'(OSC_PERIOD_NS / CLK_PERIOD_NS); // Clocks per oscillator period

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed
  {
    logic [15:0] period; // Period register value
    logic [15:0] duty_buf; // Duty buffer written by software
    logic [7:0] prescale; // Prescale ratio minus one
    logic enable; // Timer running
  } cpp_cfg_t;

  typedef struct packed
  {
    logic pin; // Compare output pin level
    logic pin_oe; // Pin driven by the compare unit
    logic period_flag; // One-cycle timer interrupt flag event
  } cpp_out_t;

endpackage : cpp_pkg

// >>> hw/cpp_tick_gen.sv
// Increment tick generator: instruction clock divided by the prescaler
`timescale 1ns/1ps
`default_nettype none

module cpp_tick_gen
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [7:0] i_prescale,
  output logic o_tick
);

  // ****************************************************************
  // Divider state
  // ****************************************************************
  logic [1:0] instr_q; // Oscillator periods within instruction cycle
  logic [1:0] instr_d;
  logic [7:0] pre_q; // Instruction cycles within prescale window
  logic [7:0] pre_d;
  logic tick_q; // Registered increment tick
  logic tick_d;

  // Next-state: four oscillator periods, then the prescale count
  always_comb
  begin
    instr_d = instr_q;
    pre_d = pre_q;
    tick_d = 1'b0;
    if (!i_enable)
    begin
      // Stopped timer restarts its phase cleanly
      instr_d = 2'h0;
      pre_d = cpp_pkg::PRE_RST;
    end
    else if (instr_q == cpp_pkg::INSTR_DIV_LAST)
    begin
      instr_d = 2'h0;
      if (pre_q >= i_prescale)
      begin
        // Compare with >= so a lowered ratio never overruns
        pre_d = cpp_pkg::PRE_RST;
        tick_d = 1'b1;
      end
      else
      begin
        pre_d = pre_q + 8'h01;
      end
    end
    else
    begin
      instr_d = instr_q + 2'h1;
    end
  end

  // Registers only
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      instr_q <= 2'h0;
      pre_q <= cpp_pkg::PRE_RST;
      tick_q <= 1'b0;
    end
    else
    begin
      instr_q <= instr_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;

endmodule : cpp_tick_gen

`default_nettype wire

// >>> hw/cpp_pwm_top.sv
// Compare PWM period and duty-reload logic, top level
//
// Overview of operation
// - Period is (period+1) times four times (prescale+1)
// - Count equal period: next tick clears, pin high
// - Zero duty keeps pin low at rollover
// - Duty above period keeps pin high
// - Rollover copies duty buffer into active duty
// - Rollover raises the timer interrupt flag
`timescale 1ns/1ps
`default_nettype none

module cpp_pwm_top
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire cpp_pkg::cpp_cfg_t i_cfg,
  output cpp_pkg::cpp_out_t o_out,
  output logic [15:0] o_timebase_timer_count,
  output logic [15:0] o_duty_active_register
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0]
  {
    CPP_IDLE = 2'b00, // Timer stopped, pin low
    CPP_RUN = 2'b01 // Timer counting
  } cpp_state_t;

  cpp_state_t state_q; // Run state
  cpp_state_t state_d;
  logic [15:0] cnt_q; // Timebase timer count
  logic [15:0] cnt_d;
  logic [15:0] duty_q; // Active duty compare value
  logic [15:0] duty_d;
  logic pin_q; // Compare output pin
  logic pin_d;
  logic oe_q; // Pin owned by the compare unit
  logic oe_d;
  logic flag_q; // Timer interrupt flag event
  logic flag_d;
  logic tick; // Increment cycle strobe

  // Level at the period start for a given duty
  function automatic logic start_level(input logic [15:0] duty);
    start_level = (duty != cpp_pkg::DUTY_ZERO);
  endfunction : start_level

  // ****************************************************************
  // Increment tick
  // ****************************************************************
  cpp_tick_gen u_tick
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_enable(i_cfg.enable),
    .i_prescale(i_cfg.prescale),
    .o_tick(tick)
  );

  // ****************************************************************
  // Period, duty and pin next-state
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    duty_d = duty_q;
    pin_d = pin_q;
    oe_d = oe_q;
    flag_d = 1'b0;
    case (state_q)
      CPP_IDLE:
      begin
        // Load the first duty so the first period is correct
        pin_d = 1'b0;
        oe_d = 1'b0;
        cnt_d = cpp_pkg::CNT_RST;
        if (i_cfg.enable)
        begin
          state_d = CPP_RUN;
          oe_d = 1'b1;
          duty_d = i_cfg.duty_buf;
          pin_d = start_level(i_cfg.duty_buf);
        end
      end
      CPP_RUN:
      begin
        if (!i_cfg.enable)
        begin
          // Stop releases the pin and clears the count on the same edge
          state_d = CPP_IDLE;
          pin_d = 1'b0;
          oe_d = 1'b0;
          cnt_d = cpp_pkg::CNT_RST;
        end
        else if (tick)
        begin
          if (cnt_q == i_cfg.period)
          begin
            // Rollover: clear, reload, set pin, flag
            cnt_d = cpp_pkg::CNT_RST;
            duty_d = i_cfg.duty_buf;
            pin_d = start_level(i_cfg.duty_buf);
            flag_d = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q + 16'h0001;
            // Duty above period never matches, so pin stays high
            if ((cnt_q + 16'h0001) == duty_q)
            begin
              pin_d = 1'b0;
            end
          end
        end
      end
      default:
      begin
        state_d = CPP_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= CPP_IDLE;
      cnt_q <= cpp_pkg::CNT_RST;
      duty_q <= cpp_pkg::DUTY_RST;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      duty_q <= duty_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      flag_q <= flag_d;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  // One driver for the whole carrier, fields straight from flip-flops
  assign o_out = '{pin: pin_q, pin_oe: oe_q, period_flag: flag_q};
  assign o_timebase_timer_count = cnt_q;
  assign o_duty_active_register = duty_q;

endmodule : cpp_pwm_top

`default_nettype wire

// >>> test/cpp_load_model.sv
// Load on the compare pin that measures the high time of each period
`timescale 1ns/1ps
`default_nettype none
module cpp_load_model
(
  input wire logic i_ref_clk,
  input wire logic i_pin,
  input wire logic i_pin_oe,
  input wire logic i_flag,
  output logic [15:0] o_hi
);
  logic [15:0] acc = 16'h0000; // High clocks so far
  wire logic level = i_pin_oe & i_pin; // Pull-down when undriven
  initial o_hi = 16'h0000;
  // Flag closes one period: latch the total, start anew
  always @(posedge i_ref_clk)
  begin
    if (i_flag)
    begin
      o_hi <= acc;
      acc <= 16'(level);
    end
    else
      acc <= acc + 16'(level);
  end
endmodule : cpp_load_model
`default_nettype wire

// >>> test/cpp_pwm_chk.sv
// Checker of the compare PWM pin, counter and reload
`timescale 1ns/1ps
`default_nettype none
module cpp_pwm_chk
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire cpp_pkg::cpp_cfg_t i_cfg,
  input wire cpp_pkg::cpp_out_t o_out,
  input wire logic [15:0] o_timebase_timer_count,
  input wire logic [15:0] o_duty_active_register
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [15:0] c = o_timebase_timer_count;
  wire logic [15:0] d = o_duty_active_register;
  AST_FLAG_ONE: assert property (o_out.period_flag |=> !o_out.period_flag) else $error("flag wide");
  AST_FLAG_CAUSE: assert property (o_out.period_flag |-> c == 16'h0000 && $past(c) == $past(i_cfg.period))
    else $error("bad rollover");
  AST_ROLL_PIN: assert property (o_out.period_flag |-> o_out.pin == (d != 16'h0000)) else $error("pin");
  AST_RELOAD: assert property (o_out.period_flag |-> d == $past(i_cfg.duty_buf)) else $error("reload");
  AST_HIGH_OVER: assert property (o_out.pin_oe && $past(o_out.pin_oe) && $past(o_out.pin)
    && $past(d) > $past(i_cfg.period) |-> o_out.pin) else $error("pin fell");
  AST_LOW_DUTY: assert property ($changed(c) && c != 16'h0000 && c == d |-> !o_out.pin) else $error("high");
  AST_CNT_STEP: assert property (o_out.pin_oe && $changed(c) && c != 16'h0000 |-> c == $past(c) + 16'h0001)
    else $error("step");
  AST_TICK_GAP: assert property (o_out.pin_oe && $changed(c) && i_cfg.prescale == 8'h00
    |=> $stable(c) [*3]) else $error("gap");
  AST_IDLE: assert property (!i_cfg.enable |=> !o_out.pin_oe && !o_out.pin) else $error("idle");
  CV_ROLL: cover property (o_out.period_flag);
  CV_ZERO: cover property (o_out.period_flag && !o_out.pin);
  CV_OVER: cover property (o_out.period_flag && d > i_cfg.period);
endmodule : cpp_pwm_chk
bind cpp_pwm_top cpp_pwm_chk chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg), .o_out(o_out),
  .o_timebase_timer_count(o_timebase_timer_count), .o_duty_active_register(o_duty_active_register));
`default_nettype wire

// >>> test/compare_pwm_period_logic_tb_top.sv
// Testbench of the compare PWM period logic
`timescale 1ns/1ps
`default_nettype none
module compare_pwm_period_logic_tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  cpp_pkg::cpp_cfg_t cfg = '0;
  cpp_pkg::cpp_out_t out;
  logic [15:0] cnt;
  logic [15:0] duty;
  logic [15:0] hi;
  int errors = 0;
  int checks_done = 0;
  int n;
  initial forever #2 i_ref_clk = ~i_ref_clk;
  cpp_pwm_top uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .o_out(out),
    .o_timebase_timer_count(cnt), .o_duty_active_register(duty));
  cpp_load_model load (.i_ref_clk(i_ref_clk), .i_pin(out.pin), .i_pin_oe(out.pin_oe),
    .i_flag(out.period_flag), .o_hi(hi));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Bounded wait for the rollover flag, returns clocks waited
  task wait_flag(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge i_ref_clk);
      #1;
      cyc++;
    end
    while (out.period_flag !== 1'b1 && cyc < 2000);
    if (cyc >= 2000)
    begin
      errors++;
      finish_test();
    end
  endtask : wait_flag
  // Start, skip the first period, time one whole period
  task run(input logic [15:0] per, input logic [15:0] dty, input logic [7:0] pre);
    @(posedge i_ref_clk);
    cfg <= '{per, dty, pre, 1'b1};
    wait_flag(n);
    wait_flag(n);
    @(posedge i_ref_clk);
    #1;
  endtask : run
  // Stop just after rollover, while the count still rests at zero
  task stop;
    @(posedge i_ref_clk);
    cfg.enable <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("oe", {31'h0, out.pin_oe}, 32'h0);
    check("count", cnt, 32'h0);
  endtask : stop
  task t_walk;
    run(16'h0003, 16'h0002, 8'h00);
    check("period", n, 32'h10);
    check("high", hi, 32'h8);
    stop();
  endtask : t_walk
  task t_zero;
    run(16'h0003, 16'h0000, 8'h00);
    check("high zero", hi, 32'h0);
    stop();
  endtask : t_zero
  task t_over;
    run(16'h0003, 16'h0005, 8'h00);
    check("high over", hi, 32'h10);
    stop();
  endtask : t_over
  task t_pre;
    run(16'h0002, 16'h0001, 8'h01);
    check("period pre", n, 32'h18);
    check("high pre", hi, 32'h8);
    stop();
  endtask : t_pre
  // Duty change mid-period waits for the rollover
  task t_reload;
    run(16'h0003, 16'h0001, 8'h00);
    @(posedge i_ref_clk);
    cfg.duty_buf <= 16'h0003;
    repeat (5) @(posedge i_ref_clk);
    #1;
    check("count mid", cnt, 32'h1);
    check("duty held", duty, 32'h1);
    wait_flag(n);
    check("duty new", duty, 32'h3);
    stop();
  endtask : t_reload
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    #1;
    check("reset pin", {31'h0, out.pin}, 32'h0);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_walk();
    t_zero();
    t_over();
    t_pre();
    t_reload();
    finish_test();
  end
endmodule : compare_pwm_period_logic_tb_top
`default_nettype wire
